//--- hw/elbs_lane_map.sv
// Combinational lane mapper: places register bytes at memory byte lanes.
// Assumes memory lane byte k holds address base+k; mapping is symmetric for
// loads when used with register and memory roles swapped.
`timescale 1ns/100ps
module elbs_lane_map
  import elbs_pkg::*;
(
  // Request bundle
  elbs_req_if.map p
);
  // ==========================================================================
  // Lane steering
  // Size in bytes of an access, used for both mapping and enables.
  function automatic int elbs_bytes(input elbs_size_t s);
    unique case (s)
      ELBS_SZ_BYTE: elbs_bytes = 1;
      ELBS_SZ_HALF: elbs_bytes = 2;
      ELBS_SZ_WORD: elbs_bytes = 4;
      ELBS_SZ_DBL:  elbs_bytes = 8;
      ELBS_SZ_TWIN: elbs_bytes = 8;
      default:      elbs_bytes = 16;
    endcase
  endfunction

  // Byte i of the register value goes to offset + position, where position
  // depends on the order. Little-endian twin words are swapped per 32-bit half.
  always_comb
  begin
    int n;
    int pos;
    int lane;
    pos  = 0;
    lane = 0;
    n = elbs_bytes(p.size);
    p.mem_data = '0;
    p.byte_en  = '0;
    for (int i = 0; i < ELBS_LANE_BYTES; i++)
    begin
      pos = 0;
      if (i < n)
      begin
        if (p.size == ELBS_SZ_TWIN)
          pos = (i < ELBS_WORD_BYTES) ?
                (p.little ? ELBS_WORD_BYTES + i : 2*ELBS_WORD_BYTES - 1 - i) :
                (p.little ? i - ELBS_WORD_BYTES : 2*ELBS_WORD_BYTES - 1 - i);
        else if (p.little)
          pos = i;
        else
          pos = n - 1 - i;
        lane = (int'(p.offset) + pos) % ELBS_LANE_BYTES;
        p.mem_data[lane*8 +: 8] = p.reg_data[i*8 +: 8];
        p.byte_en[lane] = 1'b1;
      end
    end
  end
endmodule // elbs_lane_map

//--- hw/elbs_pkg.sv
// Package for the byte-lane steering block: access sizes, address space
// identifier codes and lane geometry. Assumes a 128-bit memory lane.
package elbs_pkg;
  // ==========================================================================
  // Geometry
  localparam int ELBS_LANE_BYTES = 16;
  localparam int ELBS_LANE_BITS  = 128;
  localparam int ELBS_OFS_BITS   = 4;
  localparam int ELBS_TL_BITS    = 3;
  localparam int ELBS_WORD_BYTES = 4;

  // ==========================================================================
  // Access sizes
  typedef enum logic [2:0] {
    ELBS_SZ_BYTE = 3'h0,
    ELBS_SZ_HALF = 3'h1,
    ELBS_SZ_WORD = 3'h2,
    ELBS_SZ_DBL  = 3'h3,
    ELBS_SZ_TWIN = 3'h4,
    ELBS_SZ_QUAD = 3'h5
  } elbs_size_t;

  // ==========================================================================
  // Address space identifiers; the little variants differ in bit 3.
  localparam logic [7:0] ELBS_ASI_PRIMARY        = 8'h80;
  localparam logic [7:0] ELBS_ASI_PRIMARY_LITTLE = 8'h88;
  localparam logic [7:0] ELBS_ASI_NUCLEUS        = 8'h04;
  localparam logic [7:0] ELBS_ASI_NUCLEUS_LITTLE = 8'h0c;
  localparam int         ELBS_ASI_LITTLE_BIT     = 3;
endpackage

//--- hw/elbs_req_if.sv
// Interface carrying one steering request from the top to the lane mapper.
// Assumes a single clock domain; purely combinational bundle.
`timescale 1ns/100ps
interface elbs_req_if;
  import elbs_pkg::*;
  logic [127:0] reg_data;
  logic [3:0]   offset;
  elbs_size_t   size;
  logic         little;
  logic [127:0] mem_data;
  logic [15:0]  byte_en;
  modport top (output reg_data, offset, size, little, input mem_data, byte_en);
  modport map (input reg_data, offset, size, little, output mem_data, byte_en);
endinterface

//--- hw/elbs_top.sv
// Byte-lane steering for the load/store path of a processor.
// Assumes register data arrives low-aligned: bits 7:0 are least significant;
// for twin words bits 31:0 are the odd register, 63:32 the even register.
`timescale 1ns/100ps
module elbs_top
  import elbs_pkg::*;
(
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  // Request
  input  wire logic         i_valid,
  input  wire logic         i_fetch,
  input  wire logic         i_alternate,
  input  wire logic [7:0]   i_explicit_asi,
  input  wire logic [2:0]   i_trap_level,
  input  wire logic         i_little_endian_default_flag,
  input  wire elbs_size_t   i_size,
  input  wire logic [3:0]   i_offset,
  input  wire logic [127:0] i_reg_data,
  // Steered result
  output logic              o_valid,
  output logic [7:0]        o_asi,
  output logic              o_little,
  output logic [127:0]      o_mem_data,
  output logic [15:0]       o_byte_en
);
  // ==========================================================================
  // Identifier selection
  elbs_req_if req ();
  logic [7:0] asi_sel;
  logic       little_sel;

  // True when an identifier code is one of the little-endian variants.
  function automatic logic elbs_is_little(input logic [7:0] a);
    elbs_is_little = a[ELBS_ASI_LITTLE_BIT];
  endfunction

  always_comb
  begin
    if (i_fetch)
      asi_sel = (i_trap_level == '0) ? ELBS_ASI_PRIMARY : ELBS_ASI_NUCLEUS;
    else if (i_alternate)
      asi_sel = i_explicit_asi;
    else if (i_trap_level == '0)
      asi_sel = i_little_endian_default_flag ? ELBS_ASI_PRIMARY_LITTLE : ELBS_ASI_PRIMARY;
    else
      asi_sel = i_little_endian_default_flag ? ELBS_ASI_NUCLEUS_LITTLE : ELBS_ASI_NUCLEUS;
    little_sel = !i_fetch && elbs_is_little(asi_sel);
  end

  assign req.reg_data = i_reg_data;
  assign req.offset   = i_offset;
  assign req.size     = i_size;
  assign req.little   = little_sel;

  elbs_lane_map u_map (
    .p (req.map)
  );

  // ==========================================================================
  // Output registers; one cycle from request to result.
  logic         valid_reg, valid_next, little_reg, little_next;
  logic [7:0]   asi_reg, asi_next;
  logic [127:0] data_reg, data_next;
  logic [15:0]  en_reg, en_next;

  always_comb
  begin
    valid_next  = i_valid;
    asi_next    = i_valid ? asi_sel : asi_reg;
    little_next = i_valid ? little_sel : little_reg;
    data_next   = i_valid ? req.mem_data : data_reg;
    en_next     = i_valid ? req.byte_en : '0;
  end

  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      valid_reg  <= 1'b0;
      asi_reg    <= 8'h00;
      little_reg <= 1'b0;
      data_reg   <= '0;
      en_reg     <= 16'h0000;
    end
    else
    begin
      valid_reg  <= valid_next;
      asi_reg    <= asi_next;
      little_reg <= little_next;
      data_reg   <= data_next;
      en_reg     <= en_next;
    end
  end

  assign o_valid    = valid_reg;
  assign o_asi      = asi_reg;
  assign o_little   = little_reg;
  assign o_mem_data = data_reg;
  assign o_byte_en  = en_reg;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  a_fetch_big_order: assert property (i_valid && i_fetch |=> !o_little)
    else $error("fetch steered little-endian");
  a_asi_little_sel: assert property (i_valid && !i_fetch && i_alternate |=>
    o_little == $past(i_explicit_asi[ELBS_ASI_LITTLE_BIT]))
    else $error("explicit identifier order wrong");
  a_default_flag_order: assert property (i_valid && !i_fetch && !i_alternate |=>
    o_little == $past(i_little_endian_default_flag))
    else $error("default flag ignored");
  a_implicit_asi_pick: assert property (i_valid && !i_fetch && !i_alternate
    && i_trap_level != '0 && i_little_endian_default_flag
    |=> o_asi == ELBS_ASI_NUCLEUS_LITTLE)
    else $error("implicit identifier wrong");
  a_byte_single_lane: assert property (i_valid && i_size == ELBS_SZ_BYTE |=>
    o_byte_en == (16'h0001 << $past(i_offset))
    && o_mem_data[8*$past(i_offset) +: 8] == $past(i_reg_data[7:0]))
    else $error("byte access lane wrong");
  a_big_half_lane: assert property (i_valid && i_size == ELBS_SZ_HALF && !little_sel
    && i_offset == 4'h0 |=> o_mem_data[15:0] == {$past(i_reg_data[7:0]),
    $past(i_reg_data[15:8])})
    else $error("big halfword order wrong");
  a_big_word_lane: assert property (i_valid && i_size == ELBS_SZ_WORD && !little_sel
    && i_offset == 4'h0 |=> o_mem_data[7:0] == $past(i_reg_data[31:24])
    && o_mem_data[31:24] == $past(i_reg_data[7:0]))
    else $error("big word order wrong");
  a_big_dbl_lane: assert property (i_valid && i_size == ELBS_SZ_DBL && !little_sel
    && i_offset == 4'h0 |=> o_mem_data[7:0] == $past(i_reg_data[63:56]))
    else $error("big doubleword order wrong");
  // A quadword at a nonzero offset wraps round the lane, so the ends are
  // located from the offset rather than from lane zero.
  a_big_quad_lane: assert property (i_valid && i_size == ELBS_SZ_QUAD && !little_sel
    |=> o_mem_data[8*$past(i_offset) +: 8] == $past(i_reg_data[127:120])
    && o_mem_data[8*4'($past(i_offset) - 4'h1) +: 8] == $past(i_reg_data[7:0]))
    else $error("big quadword order wrong");
  a_little_half_lane: assert property (i_valid && i_size == ELBS_SZ_HALF && little_sel
    && i_offset == 4'h0 |=> o_mem_data[15:0] == $past(i_reg_data[15:0]))
    else $error("little halfword order wrong");
  a_little_word_lane: assert property (i_valid && i_size == ELBS_SZ_WORD && little_sel
    && i_offset == 4'h0 |=> o_mem_data[31:0] == $past(i_reg_data[31:0]))
    else $error("little word order wrong");
  a_little_dbl_lane: assert property (i_valid && i_size == ELBS_SZ_DBL && little_sel
    && i_offset == 4'h0 |=> o_mem_data[63:0] == $past(i_reg_data[63:0]))
    else $error("little doubleword order wrong");
  a_twin_word_split: assert property (i_valid && i_size == ELBS_SZ_TWIN && little_sel
    && i_offset == 4'h0 |=> o_mem_data[31:0] == $past(i_reg_data[63:32])
    && o_mem_data[63:32] == $past(i_reg_data[31:0]))
    else $error("twin word pairing wrong");
  a_little_quad_lane: assert property (i_valid && i_size == ELBS_SZ_QUAD && little_sel
    && i_offset == 4'h0 |=> o_mem_data == $past(i_reg_data))
    else $error("little quadword order wrong");

  // quadword ends anywhere
  // The full pattern is pinned at offset zero above; here only the two ends
  // are followed round the wrap for every offset, zero included.
  a_little_quad_ends: assert property (i_valid && i_size == ELBS_SZ_QUAD
    && little_sel |=> o_mem_data[8*$past(i_offset) +: 8] == $past(i_reg_data[7:0])
    && o_mem_data[8*4'($past(i_offset) - 4'h1) +: 8] == $past(i_reg_data[127:120]))
    else $error("little quadword ends wrong");

  // big twin as doubleword
  // A big-endian twin word needs no split: even register first, as one doubleword.
  a_big_twin_lane: assert property (i_valid && i_size == ELBS_SZ_TWIN
    && !little_sel && i_offset == 4'h0 |=> o_mem_data[7:0] == $past(i_reg_data[63:56])
    && o_mem_data[63:56] == $past(i_reg_data[7:0]))
    else $error("big twin word order wrong");

  // fetch identifier
  // Fetches take their identifier from the trap level alone.
  a_fetch_asi_pick: assert property (i_valid && i_fetch |=>
    o_asi == (($past(i_trap_level) == '0) ? ELBS_ASI_PRIMARY : ELBS_ASI_NUCLEUS))
    else $error("fetch identifier wrong");

  a_alt_asi_pass: assert property (i_valid && !i_fetch && i_alternate
    |=> o_asi == $past(i_explicit_asi))
    else $error("explicit identifier not used");

  a_primary_little_pick: assert property (i_valid && !i_fetch && !i_alternate
    && i_trap_level == '0 && i_little_endian_default_flag
    |=> o_asi == ELBS_ASI_PRIMARY_LITTLE)
    else $error("implicit primary identifier wrong");

  // Handshake-free contract: every request is answered on the next edge, and
  // nothing strobes or changes while no request is taken.
  a_result_follows: assert property (i_valid |=> o_valid)
    else $error("result missing after request");
  a_idle_quiet: assert property (!i_valid |=> !o_valid && o_byte_en == 16'h0000)
    else $error("enables active while idle");
  a_result_holds: assert property (!i_valid |=> $stable(o_mem_data) && $stable(o_asi)
    && $stable(o_little))
    else $error("result changed while idle");

  // Main scenarios that the bench is expected to reach.
  c_fetch: cover property (i_valid && i_fetch);
  c_little_default: cover property (i_valid && !i_fetch && !i_alternate
    && i_little_endian_default_flag);
  c_twin_little: cover property (i_valid && i_size == ELBS_SZ_TWIN && little_sel);
  c_quad_big: cover property (i_valid && i_size == ELBS_SZ_QUAD && !little_sel);
  c_back_to_back: cover property (i_valid [*2]);
endmodule // elbs_top

//--- verif/elbs_mem_model.sv
// Memory model behind the steering block: one 16-byte line written by lanes.
// Assumes lanes are taken on the rising edge while valid is high.
`timescale 1ns/100ps
module elbs_mem_model
(
  // Clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  // Store lanes
  input  wire logic         i_valid,
  input  wire logic [15:0]  i_byte_en,
  input  wire logic [127:0] i_mem_data,
  // Line image
  output logic      [127:0] o_line
);
  // ==========================================================================
  // Line storage
  // Only enabled lanes change, so a stray enable shows up as corruption.
  always_ff @(posedge i_clock or negedge i_resetn)
  begin
    if (!i_resetn)
      o_line <= 128'h0;
    else if (i_valid)
      for (int k = 0; k < 16; k++)
        if (i_byte_en[k])
          o_line[8*k +: 8] <= i_mem_data[8*k +: 8];
  end
endmodule // elbs_mem_model

//--- verif/tb_elbs_top.sv
// Self-checking bench for the steering block with a memory line model.
// Assumes one request per cycle and results registered on the taking edge, checked at the next falling edge.
`timescale 1ns/100ps
module tb_elbs_top
  import elbs_pkg::*;
;
  typedef struct packed {
    logic [127:0] mem;
    logic [15:0]  en;
    logic [7:0]   asi;
    logic         lil;
  } elbs_exp_t;
  localparam logic [127:0] PAT = 128'h00112233445566778899aabbccddeeff;
  localparam logic [31:0]  ASI_SET = {ELBS_ASI_PRIMARY_LITTLE, ELBS_ASI_NUCLEUS_LITTLE,
                                      ELBS_ASI_PRIMARY, ELBS_ASI_NUCLEUS};
  logic clock, resetn, valid, fetch, alt, flag, ovalid, olittle;
  logic [7:0]   easi, oasi;
  logic [2:0]   trap_lvl, size;
  logic [3:0]   offset;
  logic [15:0]  oen;
  logic [127:0] rdata, omem, line, r;
  logic [31:0]  k;
  elbs_exp_t    q[$];
  elbs_exp_t    e;
  int           error_cnt, check_count;
  // ==========================================================================
  // Clock and instances
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  elbs_top i_elbs_top (.i_clock(clock), .i_resetn(resetn), .i_valid(valid), .i_fetch(fetch),
    .i_alternate(alt), .i_explicit_asi(easi), .i_trap_level(trap_lvl),
    .i_little_endian_default_flag(flag), .i_size(elbs_size_t'(size)), .i_offset(offset),
    .i_reg_data(rdata), .o_valid(ovalid), .o_asi(oasi), .o_little(olittle),
    .o_mem_data(omem), .o_byte_en(oen));
  elbs_mem_model i_elbs_mem_model (.i_clock(clock), .i_resetn(resetn), .i_valid(ovalid),
    .i_byte_en(oen), .i_mem_data(omem), .o_line(line));
  // ==========================================================================
  // Expected result; lane offset+i takes register byte b, wrapping mod 16.
  function automatic elbs_exp_t expect_of(logic f, logic a, logic [7:0] x, logic [2:0] t,
    logic c, logic [2:0] s, logic [3:0] o, logic [127:0] d);
    elbs_exp_t x_e;
    int n, b;
    logic [3:0] l;
    x_e = '0;
    x_e.asi = (t != 3'h0) ? ELBS_ASI_NUCLEUS : ELBS_ASI_PRIMARY;
    if (a && !f)
      x_e.asi = x;
    else if (!f && c)
      x_e.asi = (t != 3'h0) ? ELBS_ASI_NUCLEUS_LITTLE : ELBS_ASI_PRIMARY_LITTLE;
    x_e.lil = !f && x_e.asi[ELBS_ASI_LITTLE_BIT];
    n = (s == 3'h0) ? 1 : (s == 3'h1) ? 2 : (s == 3'h2) ? 4 : (s == 3'h5) ? 16 : 8;
    for (int i = 0; i < n; i++)
    begin
      b = x_e.lil ? i : n - 1 - i;
      if (s == 3'h4 && x_e.lil)
        b = (i + 4) % 8;
      l = o + 4'(i);
      x_e.mem[8*l +: 8] = d[8*b +: 8];
      x_e.en[l] = 1'b1;
    end
    return x_e;
  endfunction
  task automatic check(string what, logic [127:0] exp, logic [127:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(logic f, logic a, logic [7:0] x, logic [2:0] t, logic c,
                      logic [2:0] s, logic [3:0] o, logic [127:0] d);
    @(negedge clock);
    {valid, fetch, alt, easi, trap_lvl, flag, size, offset, rdata} <=
      {1'b1, f, a, x, t, c, s, o, d};
    q.push_back(expect_of(f, a, x, t, c, s, o, d));
  endtask
  task automatic idle();
    @(negedge clock);
    valid <= 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========================================================================
  // Monitor: a result takes the oldest note; otherwise enables must be idle.
  always @(negedge clock)
  begin
    if (resetn && ovalid === 1'b1 && q.size() > 0)
    begin
      e = q.pop_front();
      check("lanes", e.mem, omem);
      check("enables", 128'(e.en), 128'(oen));
      check("asi", 128'(e.asi), 128'(oasi));
      check("order", 128'(e.lil), 128'(olittle));
    end
    else if (resetn)
      check("idle", 128'h0, 128'({ovalid, oen}));
  end
  // ==========================================================================
  // Main sequence: walk, all sizes both orders, identifiers, random, reset.
  initial
  begin
    {valid, fetch, alt, easi, trap_lvl, flag, size, offset, rdata} = '0;
    resetn = 1'b0;
    void'($urandom(32'h6323));
    repeat (3) @(negedge clock);
    resetn <= 1'b1;
    send(0, 0, 8'h0, 3'h0, 0, 3'h2, 4'h0, 128'h11223344);
    idle();
    idle();
    check("line", 128'h44332211, line);
    $display("test walk done");
    for (int m = 0; m < 12; m++)
      send(0, 0, 8'h0, 3'h0, m[0], 3'(m / 2), 4'(m), PAT);
    // Aligned pass too, so the offset-zero lane checks see every size and order.
    for (int m = 0; m < 12; m++)
      send(0, 0, 8'h0, 3'h0, m[0], 3'(m / 2), 4'h0, PAT);
    $display("test sizes done");
    for (int m = 0; m < 8; m++)
      send(m[0], 0, 8'h0, 3'(m[1] * 5), m[2], 3'h2, 4'h2, PAT);
    for (int j = 0; j < 4; j++)
      send(0, 1, ASI_SET[8*j +: 8], 3'h0, 1, 3'h3, 4'h0, PAT);
    $display("test identifiers done");
    repeat (300)
    begin
      r = {$urandom, $urandom, $urandom, $urandom};
      k = $urandom;
      send(k[0], !k[0] && k[1], k[9:2], k[12:10], k[13], 3'(k[16:14] % 6), k[20:17], r);
    end
    $display("test random done");
    send(0, 0, 8'h0, 3'h1, 1, 3'h5, 4'h7, PAT);
    @(negedge clock);
    valid <= 1'b0;
    resetn <= 1'b0;
    @(negedge clock);
    check("reset", 128'h0, omem | 128'({ovalid, oen, oasi, olittle}));
    resetn <= 1'b1;
    $display("test reset done");
    for (int w = 0; w < 10 && q.size() > 0; w++)
      idle();
    if (q.size() > 0)
      check("drain", 128'h0, 128'(q.size()));
    final_report();
  end
endmodule // tb_elbs_top
